// ---- rtl/rse_regs.vh ----
// constants for the rom/eeprom socket access block
`ifndef RSE_REGS_VH
`define RSE_REGS_VH
`define RSE_LATCH_PORT      8'hD8
`define RSE_LATCH_RESET     8'h00
`define RSE_CS_FIRST        8'h80
`define RSE_CS_LAST         8'h9F
`define RSE_CS_EE_LAST      8'h81
`define RSE_SOCKETS         32
`define RSE_EMPTY_PART      24'hFFFFFF
`define RSE_CLK_HZ          100000000
`define RSE_PULSE_MIN_US    12800
`define RSE_PULSE_MAX_US    13000
`define RSE_PULSE_NOM_US    12900
`define RSE_PULSE_CYCLES    ((`RSE_PULSE_NOM_US * (`RSE_CLK_HZ / 1000000)))
`endif

// ---- rtl/rse_pulse_timer.v ----
// programming pulse timer for the erasable sockets
module rse_pulse_timer #(
    parameter CYCLES = 1290000
) (
    input  wire clk_in,    // clock
    input  wire reset_in,  // sync reset
    input  wire start_in,  // start pulse
    output reg  busy_out   // pulse active
);
    reg [31:0] count;
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            busy_out <= 1'b0;
            count    <= 32'h0;
        end
        else if (start_in && !busy_out)
        begin
            busy_out <= 1'b1;
            count    <= CYCLES - 1;
        end
        else if (busy_out)
        begin
            if (count == 32'h0)
                busy_out <= 1'b0;
            else
                count <= count - 32'h1;
        end
    end
endmodule // rse_pulse_timer

// ---- rtl/rse_socket_access.v ----
// rom/eeprom socket access: write latch, socket select, eeprom programming
// Overview of operation
// - the byte latch at i/o port D8 reads back the last byte written, for all 256 values.
// - each memory socket has its own chip-select address from 80 to 9F.
// - selects 80 and 81 reach the erasable sockets and 82 to 9F the read-only sockets.
// - an empty socket reads its part number as FFFFFF, which the controller takes as no part.
// - a byte written to an erasable socket starts a programming pulse of 12.8 to 13.0 ms.
// - ram inhibit is asserted for as long as any erasable programming runs.
// - each programmed erasable location reads back its byte, 55 and AA included.
`include "rse_regs.vh"
module rse_socket_access #(
    parameter ADDR_W      = 12,
    parameter PULSE_CYCLES = `RSE_PULSE_CYCLES
) (
    input  wire              clk_in,          // 100 mhz clock
    input  wire              reset_in,        // sync reset, high
    input  wire [7:0]        io_addr_in,      // i/o port address
    input  wire              io_wr_in,        // i/o write strobe
    input  wire              io_rd_in,        // i/o read strobe
    input  wire [7:0]        io_wdata_in,     // i/o write data
    output reg  [7:0]        io_rdata_out,    // i/o read data
    input  wire [7:0]        cs_addr_in,      // memory chip-select address
    input  wire              mem_sel_in,      // memory cycle active
    input  wire              mem_wr_in,       // memory write strobe
    input  wire              mem_rd_in,       // memory read strobe
    input  wire [ADDR_W-1:0] mem_addr_in,     // address within socket
    input  wire [7:0]        mem_wdata_in,    // memory write data
    output reg  [7:0]        mem_rdata_out,   // memory read data
    input  wire [31:0]       fitted_in,       // socket populated flags
    input  wire [7:0]        rom_data_in,     // data from selected rom socket
    output reg  [31:0]       sock_sel_out,    // one-hot socket selects
    output wire              prog_busy_out,   // programming in progress
    output wire              ram_inhibit_out  // blocks system memory
);
    localparam DEPTH = 1 << ADDR_W;

    reg  [7:0]        board_write_latch;
    reg  [7:0]        ee0 [0:DEPTH-1];
    reg  [7:0]        ee1 [0:DEPTH-1];
    reg               start;
    reg  [31:0]       next_sel;
    wire              in_range;
    wire [4:0]        sock;
    wire              is_ee;
    wire              busy;

    assign in_range = (cs_addr_in >= `RSE_CS_FIRST) && (cs_addr_in <= `RSE_CS_LAST);
    assign sock     = cs_addr_in[4:0];
    assign is_ee    = in_range && (cs_addr_in <= `RSE_CS_EE_LAST);

    always @*
    begin
        next_sel = 32'h0;
        if (mem_sel_in && in_range)
            next_sel[sock] = 1'b1;
    end

    always @(posedge clk_in)
    begin
        if (reset_in)
            sock_sel_out <= 32'h0;
        else
            sock_sel_out <= next_sel;
    end

    // write latch
    always @(posedge clk_in)
    begin
        if (reset_in)
            board_write_latch <= `RSE_LATCH_RESET;
        else if (io_wr_in && io_addr_in == `RSE_LATCH_PORT)
            board_write_latch <= io_wdata_in;
    end

    always @(posedge clk_in)
    begin
        if (reset_in)
            io_rdata_out <= 8'h00;
        else if (io_rd_in && io_addr_in == `RSE_LATCH_PORT)
            io_rdata_out <= board_write_latch;
    end

    // read source codes
    localparam [1:0] SRC_EMPTY = 2'b00;
    localparam [1:0] SRC_EE    = 2'b01;
    localparam [1:0] SRC_ROM   = 2'b10;

    wire              ee_wr_take;
    wire              ee_hi;
    wire              rd_take;
    reg  [1:0]        rd_src;
    reg  [7:0]        ee_word;

    // writes during a running pulse are dropped
    assign ee_wr_take = mem_sel_in && mem_wr_in && is_ee && !busy && !start;
    assign ee_hi      = sock[0];
    assign rd_take    = mem_sel_in && mem_rd_in;

    // one-cycle start strobe into the pulse timer
    always @(posedge clk_in)
    begin
        if (reset_in)
            start <= 1'b0;
        else
            start <= ee_wr_take;
    end

    // first erasable socket
    always @(posedge clk_in)
    begin
        if (ee_wr_take && !ee_hi)
        begin
            ee0[mem_addr_in] <= mem_wdata_in;
        end
    end

    // second erasable socket
    always @(posedge clk_in)
    begin
        if (ee_wr_take && ee_hi)
        begin
            ee1[mem_addr_in] <= mem_wdata_in;
        end
    end

    // stored byte of the addressed erasable socket
    always @*
    begin
        ee_word = ee0[mem_addr_in];
        if (ee_hi)
        begin
            ee_word = ee1[mem_addr_in];
        end
    end

    // pick where a memory read is answered from
    always @*
    begin
        rd_src = SRC_EMPTY;
        if (!in_range)
        begin
            rd_src = SRC_EMPTY;
        end
        else if (!fitted_in[sock])
        begin
            rd_src = SRC_EMPTY;
        end
        else if (is_ee)
        begin
            rd_src = SRC_EE;
        end
        else
        begin
            rd_src = SRC_ROM;
        end
    end

    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            mem_rdata_out <= 8'h00;
        end
        else if (rd_take)
        begin
            case (rd_src)
                SRC_EMPTY:
                begin
                    mem_rdata_out <= 8'hFF;
                end
                SRC_EE:
                begin
                    mem_rdata_out <= ee_word;
                end
                SRC_ROM:
                begin
                    mem_rdata_out <= rom_data_in;
                end
                default:
                begin
                    mem_rdata_out <= 8'hFF;
                end
            endcase
        end
    end

    rse_pulse_timer #(
        .CYCLES   (PULSE_CYCLES)
    ) u_timer (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .start_in (start),
        .busy_out (busy)
    );

    assign prog_busy_out   = busy | start;
    assign ram_inhibit_out = busy | start;
endmodule // rse_socket_access

// ---- verification/rse_checker.sv ----
// assertions for the socket access block
module rse_checker #(parameter int PC = 50) (
    input wire logic        clk_in,         // clock
    input wire logic        reset_in,       // reset
    input wire logic [7:0]  io_addr_in,     // port
    input wire logic        io_wr_in,       // write
    input wire logic        io_rd_in,       // read
    input wire logic [7:0]  io_wdata_in,    // wdata
    input wire logic [7:0]  io_rdata_out,   // rdata
    input wire logic [7:0]  cs_addr_in,     // select
    input wire logic        mem_sel_in,     // cycle
    input wire logic        mem_wr_in,      // write
    input wire logic [31:0] sock_sel_out,   // selects
    input wire logic        prog_busy_out,  // busy
    input wire logic        ram_inhibit_out // inhibit
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    wire in_rng = cs_addr_in >= 8'h80 && cs_addr_in <= 8'h9F;
    wire wr_ee = mem_sel_in && mem_wr_in && cs_addr_in[7:1] == 7'h40;
    AST_LATCH: assert property (io_wr_in && io_addr_in == 8'hD8 ##1 io_rd_in && io_addr_in == 8'hD8
        |=> io_rdata_out == $past(io_wdata_in, 2)) else $error("latch readback wrong");
    AST_SEL: assert property (mem_sel_in && in_rng
        |=> sock_sel_out == 32'h1 << ($past(cs_addr_in) - 8'h80)) else $error("socket select wrong");
    AST_SEL_OFF: assert property (mem_sel_in && !in_rng |=> sock_sel_out == 32'h0) else $error("stray select");
    AST_START: assert property (wr_ee && !prog_busy_out |=> prog_busy_out) else $error("no pulse");
    AST_CAUSE: assert property ($rose(prog_busy_out) |-> $past(wr_ee)) else $error("pulse without write");
    AST_ROM: assert property (mem_sel_in && mem_wr_in && cs_addr_in > 8'h81 |=> !$rose(prog_busy_out))
        else $error("rom write programs");
    AST_LEN: assert property ($rose(prog_busy_out) |-> ##PC prog_busy_out ##1 !prog_busy_out)
        else $error("pulse length wrong");
    AST_INH: assert property (ram_inhibit_out == prog_busy_out) else $error("inhibit mismatch");
endmodule // rse_checker
bind rse_socket_access rse_checker #(.PC(PULSE_CYCLES)) chk (.*);

// ---- verification/rse_sock_model.sv ----
// behavioural model of the memory sockets
module rse_sock_model #(parameter logic [31:0] FIT = 32'h00000C03) (
    input wire logic [31:0] sock_sel_in,  // selects
    input wire logic        clk_in,       // clock
    output logic     [31:0] fitted_out,   // populated
    output logic     [7:0]  rom_data_out  // socket data
);
    timeunit 1ns;
    timeprecision 1ns;
    assign fitted_out = FIT;
    initial rom_data_out = 8'h3C;
    // floating bus: pattern inverts every cycle while no socket is selected, C3 while one is
    always @(posedge clk_in)
        rom_data_out <= |sock_sel_in ? 8'hC3 : ~rom_data_out;
endmodule // rse_sock_model

// ---- verification/testbench.sv ----
// self-checking bench for the socket access block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 0, reset_in = 1, io_wr_in = 0, io_rd_in = 0;
    logic        mem_sel_in = 0, mem_wr_in = 0, mem_rd_in = 0, prog_busy_out, ram_inhibit_out;
    logic [7:0]  io_addr_in = 0, io_wdata_in = 0, cs_addr_in = 0, mem_wdata_in = 0, r;
    logic [7:0]  io_rdata_out, mem_rdata_out, rom_data_in, exp_q[$];
    logic [11:0] mem_addr_in = 0;
    logic [31:0] fitted_in, sock_sel_out;
    logic [1:0]  r1 = 0, r2 = 0;
    int          err_count = 0, check_count = 0, n;
    rse_socket_access #(.PULSE_CYCLES(50)) uut (.*);
    rse_sock_model model (.sock_sel_in(sock_sel_out), .clk_in, .fitted_out(fitted_in), .rom_data_out(rom_data_in));
    always #5 clk_in = ~clk_in;
    task chk(input logic [15:0] a, b);
        check_count++;
        if (a !== b)
        begin
            err_count++;
            $display("[ERR] %0t %h %h", $time, a, b);
        end
    endtask
    task print_verdict;
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_in)
        {r2, r1} <= {r1, mem_rd_in, io_rd_in};
    always @(negedge clk_in)
        if (r2 != 2'h0)
            chk(r2[1] ? mem_rdata_out : io_rdata_out, exp_q.pop_front());
    task io(input logic [7:0] d);
        {io_addr_in, io_wdata_in, io_wr_in} = {8'hD8, d, 1'b1};
        @(negedge clk_in) {io_wr_in, io_rd_in} = 2'h1;
        exp_q.push_back(d);
        @(negedge clk_in) io_rd_in = 1'b0;
        @(negedge clk_in);
    endtask
    task mem(input logic [7:0] cs, input logic [11:0] a, input logic wr, input logic [7:0] d);
        {cs_addr_in, mem_addr_in, mem_wdata_in, mem_sel_in, mem_wr_in, mem_rd_in} = {cs, a, d, 1'b1, wr, !wr};
        if (!wr)
            exp_q.push_back(d);
        @(negedge clk_in) {mem_sel_in, mem_wr_in, mem_rd_in} = 3'h0;
        @(negedge clk_in);
    endtask
    task wait_done(input int e);
        for (n = 0; prog_busy_out === 1'b1 && n < 200; n++)
            @(negedge clk_in);
        chk(n, e);
    endtask
    initial
    begin
        void'($urandom(32'hAE2D));
        repeat (2) @(negedge clk_in);
        reset_in = 1'b0;
        for (int i = 0; i < 256; i++)
            io(i[7:0]);
        for (int s = 0; s < 33; s++)
            if (s == 32 || !fitted_in[s[4:0]])
                for (int b = 0; b < 3; b++)
                    mem(8'h80 + s[7:0], b[11:0], 1'b0, 8'hFF);
        r = 8'($urandom);
        mem(8'h80, 12'h7, 1'b1, r);
        mem(8'h80, 12'h7, 1'b1, ~r);
        chk(ram_inhibit_out, 1);
        wait_done(48);
        mem(8'h80, 12'h8, 1'b1, 8'h55);
        wait_done(50);
        mem(8'h80, 12'h9, 1'b1, 8'hAA);
        wait_done(50);
        mem(8'h82, 12'h1, 1'b1, 8'h00);
        chk(prog_busy_out, 0);
        mem(8'h80, 12'h7, 1'b0, r);
        mem(8'h80, 12'h8, 1'b0, 8'h55);
        mem(8'h80, 12'h9, 1'b0, 8'hAA);
        repeat (3) @(negedge clk_in);
        print_verdict;
    end
    initial
    begin
        #50000;
        err_count++;
        print_verdict;
    end
endmodule // testbench
